// *** timer_channel_capture_config.sv ***
// four capture/compare channels: mode and enable registers, filters, capture, output stage
//
// Contract
// - codes 0101/0110/0111 sample at dts/2,/4,/4 needing 8,6,8 samples
// - codes 1100-1111 sample dts/16 N8, then dts/32 with N 5,6,8
// - prescaler field captures every 1, 2, 4 or 8 detected edges
// - capture prescaler counter resets while the channel enable bit is clear
// - direction 00 output; 01 own pin, 10 neighbour pin, 11 internal trigger
// - direction field writes are ignored while the channel is enabled
// - direction decides whether the control byte means compare or capture settings
// - mode register 0x1c high byte holds channel 4 output fields
// - mode register 0x1c low byte holds channel 3 output fields
// - input mode: ch4 filter [15:12] divider [11:10], ch3 filter [7:4] divider [3:2]
// - input mode: ch1 filter [7:4], divider [3:2], direction [1:0]
// - enable register 0x20: enable and polarity at bits 0/1, 4/5, 8/9
// - channel 4 uses bits 12/13; reserved pairs read as zero
// - all fields reset to zero: channels are disabled outputs
// - filter changes output after N equal samples; code 0000 bypasses
// - fast enable in pwm modes: trigger reaches output in 3 cycles, a compare match in 4
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module timer_channel_capture_config
    import tc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CHANNELS-1:0] chan_pin_i,
    input wire logic trc_i,
    input wire logic trig_edge_i,
    input wire logic clear_i,
    input wire logic update_i,
    input wire logic [CNT_W-1:0] count_i,
    output logic [CHANNELS-1:0] chan_out_o,
    output logic [CHANNELS-1:0] chan_oe_o,
    output logic [CHANNELS-1:0] cap_event_o
);
    logic [15:0] mode12_q;
    logic [15:0] mode34_q;
    logic [15:0] enable_q;
    logic [CNT_W-1:0] ccr_q [CHANNELS];
    logic [CNT_W-1:0] ccr_live_q [CHANNELS];
    logic [CHANNELS-1:0] ref_q;
    logic [CHANNELS-1:0] fire;
    logic [CHANNELS-1:0] filt;
    logic [CHANNELS-1:0] filt_prev_q;
    logic [CHANNELS-1:0] ch_en;
    logic [CHANNELS-1:0] ch_pol;
    logic [CHANNELS-1:0] ch_in;
    logic [CHANNELS-1:0] match;
    logic [CHANNELS-1:0] match_pipe_q [MATCH_PIPE];
    logic trig_q;
    logic trig_prev_q;

    // bus decode
    logic acc_phase;
    logic take;
    logic hit_mode12;
    logic hit_mode34;
    logic hit_enable;
    logic [CHANNELS-1:0] hit_cap;
    logic mapped;
    logic wr_take;
    logic [15:0] rd_word;

    // merge a mode-register write, keeping the direction field of an enabled channel
    function automatic logic [15:0] mode_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                               input logic en_lo, input logic en_hi);
        logic [15:0] res;
        res = new_v;
        if (en_lo) begin
            res[DIR_LSB+:2] = old_v[DIR_LSB+:2];
        end
        if (en_hi) begin
            res[8+DIR_LSB+:2] = old_v[8+DIR_LSB+:2];
        end
        return res;
    endfunction

    assign acc_phase = psel && penable;
    assign take = acc_phase && !pready;
    assign wr_take = acc_phase && pready && pwrite;
    assign hit_mode12 = (paddr == OFS_MODE12);
    assign hit_mode34 = (paddr == OFS_MODE34);
    assign hit_enable = (paddr == OFS_ENABLE);

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_dec
            localparam logic [7:0] CAP_OFS = OFS_CAP1 + 8'(gi) * OFS_CAP_STEP;
            assign hit_cap[gi] = (paddr == CAP_OFS);
        end
    endgenerate

    assign mapped = hit_mode12 || hit_mode34 || hit_enable || (|hit_cap);

    always_comb begin
        rd_word = 16'h0000;
        if (hit_mode12) begin
            rd_word = mode12_q;
        end
        if (hit_mode34) begin
            rd_word = mode34_q;
        end
        if (hit_enable) begin
            rd_word = enable_q & ENABLE_RW_MASK;
        end
        for (int k = 0; k < CHANNELS; k++) begin
            if (hit_cap[k]) begin
                rd_word = 16'(ccr_q[k]);
            end
        end
    end

    // one wait state: pready rises in the second access cycle, write lands there
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce_i) begin
            pready <= take;
            pslverr <= take && !mapped;
            if (take) begin
                prdata <= (mapped && !pwrite) ? {16'h0000, rd_word} : 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode12_q <= MODE_RST;
            mode34_q <= MODE_RST;
            enable_q <= ENABLE_RST;
        end else if (ce_i && wr_take) begin
            if (hit_mode12) begin
                mode12_q <= mode_merge(mode12_q, pwdata[15:0], ch_en[0], ch_en[1]);
            end
            if (hit_mode34) begin
                mode34_q <= mode_merge(mode34_q, pwdata[15:0], ch_en[2], ch_en[3]);
            end
            if (hit_enable) begin
                enable_q <= pwdata[15:0] & ENABLE_RW_MASK;
            end
        end
    end

    // per channel control byte and input side
    logic [7:0] cbyte [CHANNELS];
    logic [CHANNELS-1:0] src;
    logic [CHANNELS-1:0] edge_ev;

    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            localparam int PAIR = gi ^ 1;
            capture_if cap ();
            if (gi < 2) begin : g_lo
                assign cbyte[gi] = mode12_q[8*gi+:8];
            end else begin : g_hi
                assign cbyte[gi] = mode34_q[8*(gi-2)+:8];
            end
            assign ch_en[gi] = enable_q[ENA_STEP*gi+ENA_BIT];
            assign ch_pol[gi] = enable_q[ENA_STEP*gi+POL_BIT];
            assign ch_in[gi] = (cbyte[gi][DIR_LSB+:2] != DIR_OUTPUT);
            // trigger source is only meaningful with an internal trigger selected upstream
            assign src[gi] = (cbyte[gi][DIR_LSB+:2] == DIR_OWN_PIN) ? chan_pin_i[gi] :
                             (cbyte[gi][DIR_LSB+:2] == DIR_PAIR_PIN) ? chan_pin_i[PAIR] :
                             trc_i;
            assign edge_ev[gi] = ch_in[gi] &&
                                 (ch_pol[gi] ? (filt_prev_q[gi] && !filt[gi])
                                             : (!filt_prev_q[gi] && filt[gi]));
            assign cap.edge_ev = edge_ev[gi];
            assign cap.enable = ch_en[gi] && ch_in[gi];
            assign cap.div_sel = cbyte[gi][PSC_LSB+:2];
            assign fire[gi] = cap.fire;

            chan_filter u_filt (
                .clock_i(clock_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .code_i(ch_in[gi] ? cbyte[gi][FILT_LSB+:4] : 4'h0),
                .raw_i(src[gi]),
                .filt_o(filt[gi])
            );

            capture_divider u_div (
                .clock_i(clock_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .cap(cap.divider)
            );

            assign match[gi] = (count_i == ccr_live_q[gi]);
        end
    endgenerate

    // capture beats a same-cycle software write so no event is lost
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int k = 0; k < CHANNELS; k++) begin
                ccr_q[k] <= CAP_RST;
                ccr_live_q[k] <= CAP_RST;
            end
            cap_event_o <= '0;
            filt_prev_q <= '0;
        end else if (ce_i) begin
            filt_prev_q <= filt;
            cap_event_o <= fire;
            for (int k = 0; k < CHANNELS; k++) begin
                if (fire[k]) begin
                    ccr_q[k] <= count_i;
                end else if (wr_take && hit_cap[k]) begin
                    ccr_q[k] <= pwdata[CNT_W-1:0];
                end
                if (!cbyte[k][PRE_BIT] || update_i) begin
                    ccr_live_q[k] <= ccr_q[k];
                end
            end
        end
    end

    // output stage: the compare path carries extra match stages so it lags the fast path
    logic [CHANNELS-1:0] ref_d;
    logic trig_pulse;
    logic [CHANNELS-1:0] m_late;

    assign trig_pulse = trig_q && !trig_prev_q;
    assign m_late = match_pipe_q[MATCH_PIPE-1];

    always_comb begin
        for (int k = 0; k < CHANNELS; k++) begin
            logic [2:0] om;
            logic pwm;
            om = cbyte[k][MODE_LSB+:3];
            pwm = (om == OM_PWM1) || (om == OM_PWM2);
            case (om)
                OM_SET: ref_d[k] = m_late[k] ? 1'b1 : ref_q[k];
                OM_CLEAR: ref_d[k] = m_late[k] ? 1'b0 : ref_q[k];
                OM_TOGGLE: ref_d[k] = m_late[k] ? !ref_q[k] : ref_q[k];
                OM_FORCE_LO: ref_d[k] = 1'b0;
                OM_FORCE_HI: ref_d[k] = 1'b1;
                OM_PWM1: ref_d[k] = m_late[k] ? 1'b0 : ref_q[k];
                OM_PWM2: ref_d[k] = m_late[k] ? 1'b1 : ref_q[k];
                default: ref_d[k] = ref_q[k];
            endcase
            if (pwm && (count_i == '0) && !m_late[k]) begin
                ref_d[k] = (om == OM_PWM1);
            end
            if (pwm && cbyte[k][FAST_BIT] && trig_pulse) begin
                ref_d[k] = (om == OM_PWM1) ? 1'b0 : 1'b1;
            end
            if (cbyte[k][CLR_BIT] && clear_i) begin
                ref_d[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_q <= 1'b0;
            trig_prev_q <= 1'b0;
            ref_q <= '0;
            chan_out_o <= '0;
            chan_oe_o <= '0;
            for (int s = 0; s < MATCH_PIPE; s++) begin
                match_pipe_q[s] <= '0;
            end
        end else if (ce_i) begin
            trig_q <= trig_edge_i;
            trig_prev_q <= trig_q;
            match_pipe_q[0] <= match;
            for (int s = 1; s < MATCH_PIPE; s++) begin
                match_pipe_q[s] <= match_pipe_q[s-1];
            end
            ref_q <= ref_d;
            chan_out_o <= ~ch_in & ch_en & (ref_d ^ ch_pol);
            chan_oe_o <= ~ch_in & ch_en;
        end
    end
endmodule
`default_nettype wire

// *** tc_pkg.sv ***
// shared constants and decode helpers for the timer channel configuration block
package tc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MODE12 = 8'h18;
    localparam logic [7:0] OFS_MODE34 = 8'h1c;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_CAP1 = 8'h34;
    localparam logic [7:0] OFS_CAP_STEP = 8'h04;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] CAP_RST = 16'h0000;
    localparam logic [15:0] ENABLE_RW_MASK = 16'h3333;
    localparam int ENA_STEP = 4;
    localparam int ENA_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int DIR_LSB = 0;
    localparam int PSC_LSB = 2;
    localparam int FILT_LSB = 4;
    localparam int FAST_BIT = 2;
    localparam int PRE_BIT = 3;
    localparam int MODE_LSB = 4;
    localparam int CLR_BIT = 7;
    localparam logic [1:0] DIR_OUTPUT = 2'b00;
    localparam logic [1:0] DIR_OWN_PIN = 2'b01;
    localparam logic [1:0] DIR_PAIR_PIN = 2'b10;
    localparam logic [1:0] DIR_TRIGGER = 2'b11;
    localparam logic [2:0] OM_FROZEN = 3'h0;
    localparam logic [2:0] OM_SET = 3'h1;
    localparam logic [2:0] OM_CLEAR = 3'h2;
    localparam logic [2:0] OM_TOGGLE = 3'h3;
    localparam logic [2:0] OM_FORCE_LO = 3'h4;
    localparam logic [2:0] OM_FORCE_HI = 3'h5;
    localparam logic [2:0] OM_PWM1 = 3'h6;
    localparam logic [2:0] OM_PWM2 = 3'h7;
    localparam int FAST_DELAY_CYC = 3;
    localparam int SLOW_DELAY_CYC = 5;
    localparam int MATCH_PIPE = SLOW_DELAY_CYC - FAST_DELAY_CYC;

    // {sample divider minus one, consecutive samples needed}
    function automatic logic [8:0] filt_cfg(input logic [3:0] code);
        case (code)
            4'h1: filt_cfg = {5'h00, 4'h2};
            4'h2: filt_cfg = {5'h00, 4'h4};
            4'h3: filt_cfg = {5'h00, 4'h8};
            4'h4: filt_cfg = {5'h01, 4'h6};
            4'h5: filt_cfg = {5'h01, 4'h8};
            4'h6: filt_cfg = {5'h03, 4'h6};
            4'h7: filt_cfg = {5'h03, 4'h8};
            4'h8: filt_cfg = {5'h07, 4'h6};
            4'h9: filt_cfg = {5'h07, 4'h8};
            4'ha: filt_cfg = {5'h0f, 4'h5};
            4'hb: filt_cfg = {5'h0f, 4'h6};
            4'hc: filt_cfg = {5'h0f, 4'h8};
            4'hd: filt_cfg = {5'h1f, 4'h5};
            4'he: filt_cfg = {5'h1f, 4'h6};
            4'hf: filt_cfg = {5'h1f, 4'h8};
            default: filt_cfg = {5'h00, 4'h0};
        endcase
    endfunction
endpackage

// *** capture_if.sv ***
// carrier between a channel and its capture event divider
`timescale 1ns/100ps
`default_nettype none
interface capture_if;
    logic edge_ev;
    logic enable;
    logic [1:0] div_sel;
    logic fire;
    modport divider (input edge_ev, input enable, input div_sel, output fire);
    modport owner (output edge_ev, output enable, output div_sel, input fire);
endinterface
`default_nettype wire

// *** chan_filter.sv ***
// digital input filter: sample divider and run-length event counter
`timescale 1ns/100ps
`default_nettype none
module chan_filter
    import tc_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [3:0] code_i,
    input wire logic raw_i,
    output logic filt_o
);
    logic [4:0] div_q;
    logic [3:0] run_q;
    logic [8:0] cfg;
    logic [4:0] div_m1;
    logic [3:0] need;
    logic tick;
    logic [3:0] run_inc;

    assign cfg = filt_cfg(code_i);
    assign div_m1 = cfg[8:4];
    assign need = cfg[3:0];
    assign tick = (div_q >= div_m1);
    assign run_inc = run_q + 4'h1;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_q <= 5'h00;
            run_q <= 4'h0;
            filt_o <= 1'b0;
        end else if (ce_i) begin
            div_q <= tick ? 5'h00 : div_q + 5'h01;
            if (code_i == 4'h0) begin
                filt_o <= raw_i;
                run_q <= 4'h0;
            end else if (tick) begin
                if (raw_i == filt_o) begin
                    run_q <= 4'h0;
                end else if (run_inc >= need) begin
                    filt_o <= raw_i;
                    run_q <= 4'h0;
                end else begin
                    run_q <= run_inc;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** capture_divider.sv ***
// capture event divider: one capture per 1, 2, 4 or 8 detected edges
`timescale 1ns/100ps
`default_nettype none
module capture_divider
    import tc_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    capture_if.divider cap
);
    logic [2:0] cnt_q;
    logic [2:0] limit;

    assign limit = (3'h1 << cap.div_sel) - 3'h1;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 3'h0;
            cap.fire <= 1'b0;
        end else if (ce_i) begin
            cap.fire <= 1'b0;
            if (!cap.enable) begin
                cnt_q <= 3'h0;
            end else if (cap.edge_ev) begin
                if (cnt_q >= limit) begin
                    cnt_q <= 3'h0;
                    cap.fire <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tc_chk_assertions.sv ***
// concurrent checks on the timer channel block ports: bus timing, reset idle, output gating
`timescale 1ns/100ps
`default_nettype none
module tc_chk
    import tc_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int CNT_W = 16
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CHANNELS-1:0] chan_pin_i,
    input wire logic trc_i,
    input wire logic trig_edge_i,
    input wire logic clear_i,
    input wire logic update_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic [CHANNELS-1:0] chan_out_o,
    input wire logic [CHANNELS-1:0] chan_oe_o,
    input wire logic [CHANNELS-1:0] cap_event_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    wire acc_w = psel & penable;

    pready_pulse_a: assert property (pready && ce_i |=> !pready)
        else $error("pready stayed high for more than one cycle");
    access_answer_a: assert property (acc_w && !pready && ce_i && !$past(acc_w) |=> pready)
        else $error("pready missing one cycle after the first access cycle");
    ready_cause_a: assert property (pready |-> $past(acc_w))
        else $error("pready without an access cycle before it");
    slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("pslverr outside pready or with nonzero read data");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    reserved_zero_a: assert property (pready && !pwrite && paddr == OFS_ENABLE |->
        (prdata[15:0] & ~ENABLE_RW_MASK) == 16'h0000)
        else $error("reserved enable register bits read nonzero");
    cap_pulse_a: assert property (|cap_event_o |=> (cap_event_o & $past(cap_event_o)) == '0)
        else $error("capture event longer than one cycle");
    reset_idle_a: assert property ($fell(sys_rst_i) |->
        chan_out_o == '0 && chan_oe_o == '0 && cap_event_o == '0)
        else $error("outputs not idle after reset release");
    out_gate_a: assert property ((chan_out_o & ~chan_oe_o) == '0)
        else $error("channel drives high while not an enabled output");

    cover property (pslverr);
    cover property (cap_event_o[0]);
    cover property (chan_oe_o[2] && chan_out_o[2]);
endmodule

bind timer_channel_capture_config tc_chk #(.CHANNELS(CHANNELS), .CNT_W(CNT_W)) i_chk (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_pin_i(chan_pin_i), .trc_i(trc_i), .trig_edge_i(trig_edge_i),
    .clear_i(clear_i), .update_i(update_i), .count_i(count_i), .chan_out_o(chan_out_o),
    .chan_oe_o(chan_oe_o), .cap_event_o(cap_event_o));
`default_nettype wire

// *** chan_pin_model.sv ***
// partner model: external drivers on the four channel pins
`timescale 1ns/100ps
`default_nettype none
module chan_pin_model (
    input wire logic clock_i,
    output logic [3:0] pins_o
);
    initial pins_o = 4'h0;

    // width and gap in clocks, so short glitches and slow pulses come from the same driver
    task automatic pulse(input int ch, input int width, input int gap);
        @(posedge clock_i);
        pins_o[ch] <= 1'b1;
        repeat (width) @(posedge clock_i);
        pins_o[ch] <= 1'b0;
        repeat (gap) @(posedge clock_i);
    endtask
endmodule
`default_nettype wire

// *** timer_channel_capture_config_tb.sv ***
// self-checking testbench for the timer channel configuration block
`timescale 1ns/100ps
`default_nettype none
module timer_channel_capture_config_tb;
    import tc_pkg::*;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] count_i = 16'h0000;
    logic trc_lvl = 1'b0;
    logic trig_lvl = 1'b0;
    logic [3:0] pins;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] chan_out_o;
    logic [3:0] chan_oe_o;
    logic [3:0] cap_event_o;
    logic [31:0] rdat;
    logic rerr;
    int err_total = 0;
    int cmp_count = 0;
    int cap_cnt = 0;
    // filter codes and sampling span in clocks: divider times consecutive samples
    logic [3:0] fcode[4] = '{4'h5, 4'h7, 4'hc, 4'hf};
    int fspan[4] = '{16, 32, 128, 256};

    timer_channel_capture_config i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_pin_i(pins),
        .trc_i(trc_lvl), .trig_edge_i(trig_lvl), .clear_i(1'b0), .update_i(1'b0),
        .count_i(count_i),
        .chan_out_o(chan_out_o), .chan_oe_o(chan_oe_o), .cap_event_o(cap_event_o));
    chan_pin_model i_pins (.clock_i(clock_i), .pins_o(pins));

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) if (cap_event_o[0] === 1'b1) cap_cnt <= cap_cnt + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [15:0] d,
             output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clock_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge clock_i);
        penable <= 1'b1;
        // the slave answers when it likes; pready or the bound of 50 cycles ends the wait
        do begin
            @(posedge clock_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 16'h0000, rdat, rerr);
        chk(rdat, exp);
    endtask

    task t_reset;
        rd(OFS_MODE12, 32'h0000_0000);
        rd(OFS_MODE34, 32'h0000_0000);
        rd(OFS_ENABLE, 32'h0000_0000);
        chk({20'h00000, chan_oe_o, chan_out_o, cap_event_o}, 32'h0);
        $display("reset test done");
    endtask

    task t_regs;
        wr(OFS_ENABLE, 16'hffff);
        rd(OFS_ENABLE, 32'h0000_3333);
        wr(OFS_ENABLE, 16'h0000);
        wr(OFS_MODE34, 16'hffff);
        rd(OFS_MODE34, 32'h0000_ffff);
        apb(1'b0, 8'h44, 16'h0000, rdat, rerr);
        chk({rerr, rdat[30:0]}, 32'h8000_0000);
        $display("register test done");
    endtask

    task t_lock;
        wr(OFS_MODE34, 16'h0000);
        wr(OFS_ENABLE, 16'h0100);
        wr(OFS_MODE34, 16'hfff3);
        rd(OFS_MODE34, 32'h0000_fff0);
        wr(OFS_ENABLE, 16'h0000);
        wr(OFS_MODE34, 16'h0003);
        rd(OFS_MODE34, 32'h0000_0003);
        $display("direction lock test done");
    endtask

    task t_out;
        wr(OFS_MODE34, 16'h0050);
        wr(OFS_ENABLE, 16'h0100);
        repeat (8) @(posedge clock_i);
        chk({30'h0, chan_oe_o[2], chan_out_o[2]}, 32'h3);
        wr(OFS_ENABLE, 16'h0300);
        repeat (8) @(posedge clock_i);
        chk({30'h0, chan_oe_o[2], chan_out_o[2]}, 32'h2);
        wr(OFS_ENABLE, 16'h0000);
        repeat (8) @(posedge clock_i);
        chk({30'h0, chan_oe_o[2], chan_out_o[2]}, 32'h0);
        $display("output test done");
    endtask

    // pwm1 held high by a count of zero, then a trigger edge with fast enable pulls it low
    task t_fast;
        wr(OFS_ENABLE, 16'h0000);
        wr(OFS_MODE34, 16'h0064);
        wr(OFS_CAP1 + 8'h08, 16'h0100);
        wr(OFS_ENABLE, 16'h0100);
        count_i <= 16'h0000;
        repeat (4) @(posedge clock_i);
        count_i <= 16'h0005;
        repeat (4) @(posedge clock_i);
        chk({31'h0, chan_out_o[2]}, 32'h1);
        trig_lvl <= 1'b1;
        repeat (2) @(posedge clock_i);
        chk({31'h0, chan_out_o[2]}, 32'h1);
        @(posedge clock_i);
        chk({31'h0, chan_out_o[2]}, 32'h0);
        trig_lvl <= 1'b0;
        wr(OFS_ENABLE, 16'h0000);
        $display("fast trigger test done");
    endtask

    // channel 1 listens to the internal trigger level, channel 2 to the neighbour pin
    task t_src;
        wr(OFS_ENABLE, 16'h0000);
        wr(OFS_MODE12, 16'h0203);
        wr(OFS_ENABLE, 16'h0011);
        count_i <= 16'h00a1;
        trc_lvl <= 1'b1;
        repeat (4) @(posedge clock_i);
        trc_lvl <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(OFS_CAP1, 32'h0000_00a1);
        count_i <= 16'h00b2;
        i_pins.pulse(0, 2, 6);
        rd(OFS_CAP1 + 8'h04, 32'h0000_00b2);
        rd(OFS_CAP1, 32'h0000_00a1);
        wr(OFS_ENABLE, 16'h0000);
        $display("input source test done");
    endtask

    task t_cap;
        for (int p = 0; p < 4; p++) begin
            wr(OFS_ENABLE, 16'h0000);
            wr(OFS_MODE12, 16'h0001 | 16'(p << 2));
            wr(OFS_ENABLE, 16'h0001);
            count_i <= 16'h1200 + 16'(p);
            cap_cnt <= 0;
            repeat (8) i_pins.pulse(0, 2, 2);
            repeat (8) @(posedge clock_i);
            chk(cap_cnt, 32'(8 >> p));
            rd(OFS_CAP1, 32'h1200 + 32'(p));
        end
        cap_cnt <= 0;
        repeat (4) i_pins.pulse(0, 2, 2);
        wr(OFS_ENABLE, 16'h0000);
        wr(OFS_ENABLE, 16'h0001);
        repeat (4) i_pins.pulse(0, 2, 2);
        repeat (8) @(posedge clock_i);
        chk(cap_cnt, 32'h0);
        $display("capture divider test done");
    endtask

    task t_filt;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_ENABLE, 16'h0000);
            wr(OFS_MODE12, {8'h00, fcode[k], 4'h1});
            wr(OFS_ENABLE, 16'h0001);
            cap_cnt <= 0;
            i_pins.pulse(0, fspan[k] / 2, fspan[k]);
            chk(cap_cnt, 32'h0);
            i_pins.pulse(0, fspan[k] * 2, fspan[k] * 2);
            chk(cap_cnt, 32'h1);
        end
        $display("filter test done");
    endtask

    task test_done;
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_reset;
        t_regs;
        t_lock;
        t_out;
        t_fast;
        t_src;
        t_cap;
        t_filt;
        test_done;
    end

    // the whole sequence needs well under 6000 clocks
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
